//--- hdl/flk_top.v
// serial flash command interpreter: security read, lock bits, identity reads
// assumes link pins are asynchronous and sampled by the 40 MHz system clock
`timescale 1ns/1ps
`include "flk_regs.vh"
module flk_top #(
  parameter [7:0] MAKER_CODE = 8'h5A, // arbitrary value
  parameter [7:0] DEVICE_CODE = 8'hC3, // arbitrary value
  parameter [127:0] UNIQUE_ID = 128'h0123456789ABCDEFFEDCBA9876543210 // arbitrary
) (
  // system
  input wire CLK_SYS,
  input wire RST,
  // link pins
  input wire SCLK,
  input wire CS_N,
  input wire [3:0] IO_IN,
  output reg [3:0] IO_OUT,
  output reg [3:0] IO_OE,
  // device state
  input wire BUSY,
  input wire WRITE_ENABLE_LATCH,
  input wire PROTECTION_SCHEME_SELECT,
  input wire PROTECT_COMPLEMENT,
  input wire SECTOR_GRANULARITY,
  input wire TOP_BOTTOM_SELECT,
  input wire [2:0] BLOCK_PROTECT_FIELD,
  input wire [7:0] CHECK_INDEX,
  // security register array read port
  output reg [11:0] SEC_ADDR,
  input wire [7:0] SEC_DATA,
  // protection results
  output reg LOCK_BITS_ACTIVE,
  output reg INDEX_LOCKED,
  output reg WEL_CLEAR
);
  // ==========================================================
  // states
  localparam [2:0] S_OP = 3'd0;
  localparam [2:0] S_ADDR = 3'd1;
  localparam [2:0] S_DUMMY = 3'd2;
  localparam [2:0] S_DATA = 3'd3;
  localparam [2:0] S_WAIT = 3'd4;
  localparam [2:0] S_IGNORE = 3'd5;

  // two-flop synchronisers
  // reset to the idle pin levels so no false select or clock edge follows reset
  reg [5:0] s1_r;
  reg [5:0] s2_r;
  reg sclk_d_r;
  always @(posedge CLK_SYS) begin
    if (RST) begin
      s1_r <= 6'h00;
      s2_r <= 6'h00;
      sclk_d_r <= 1'b0;
    end else begin
      s1_r <= {IO_IN, SCLK, ~CS_N};
      s2_r <= s1_r;
      sclk_d_r <= s2_r[1];
    end
  end
  wire sel = s2_r[0];
  wire rise = s2_r[1] & ~sclk_d_r;
  wire fall = ~s2_r[1] & sclk_d_r;
  wire [3:0] io = s2_r[5:2];

  reg [2:0] state_r;
  reg [7:0] op_r;
  reg [23:0] addr_r;
  reg [5:0] cnt_r;
  reg [1:0] width_r;   // 0 single, 1 dual, 2 quad
  reg [7:0] obyte_r;
  reg [6:0] oidx_r;    // bit index within out stream
  reg [9:0] sec_ptr_r;
  reg [1:0] sec_reg_r;
  reg id_sel_r;
  reg pend_r;          // complete lock command seen
  reg sel_d_r;
  reg set_one;
  reg clr_one;
  reg set_all;
  reg clr_all;
  wire lock_bit;
  wire [7:0] lock_idx = addr_r[`FLK_LOCK_ADDR_MSB:`FLK_LOCK_ADDR_LSB];

  flk_lockmem u_mem (
    .clk(CLK_SYS),
    .rst(RST),
    .set_one(set_one),
    .clr_one(clr_one),
    .set_all(set_all),
    .clr_all(clr_all),
    .idx(state_r == S_OP ? CHECK_INDEX : lock_idx),
    .bit_out(lock_bit)
  );

  // bits taken per rising edge in the current phase, or given per falling edge in the data phase
  wire [5:0] step = (width_r == 2'd2) ? 6'd4 : (width_r == 2'd1) ? 6'd2 : 6'd1;
  wire [23:0] addr_shift = (width_r == 2'd2) ? {addr_r[19:0], io} :
                           (width_r == 2'd1) ? {addr_r[21:0], io[1:0]} :
                           {addr_r[22:0], io[0]};

  // next output byte for the running read
  reg [7:0] nxt_byte;
  always @* begin
    nxt_byte = 8'h00;
    case (op_r)
      // upper address byte nonzero gives zero data (undefined)
      `FLK_OP_SECRD: nxt_byte = (addr_r[23:16] != 8'h00) ? 8'h00 : SEC_DATA;
      `FLK_OP_RDLOCK: nxt_byte = {7'h00, lock_bit};
      `FLK_OP_ID2, `FLK_OP_ID4: nxt_byte = id_sel_r ? DEVICE_CODE : MAKER_CODE;
      // unique number, most significant byte first
      `FLK_OP_UID: nxt_byte = UNIQUE_ID[8'd127 - {oidx_r[6:3], 3'b000} -: 8];
      default: nxt_byte = 8'h00;
    endcase
  end

  // dummy bits to count before data, by opcode
  // counted in bits so one compare serves every lane width
  // eight dummy clocks single; mode byte alone dual; mode byte plus four dummies quad
  reg [5:0] dummy_bits;
  always @* begin
    case (op_r)
      `FLK_OP_ID2: dummy_bits = `FLK_DUMMY_ID2;
      `FLK_OP_ID4: dummy_bits = `FLK_DUMMY_ID4;
      `FLK_OP_UID: dummy_bits = `FLK_DUMMY_UID;
      default: dummy_bits = `FLK_DUMMY_SEC;
    endcase
  end

  // ==========================================================
  // output lane mapping
  // a byte start takes a fresh byte, otherwise the shifted remainder;
  // lanes not used by the current width stay released for the host
  reg [7:0] out_src;
  reg [3:0] out_lanes;
  reg [3:0] oe_lanes;
  always @* begin
    out_src = (cnt_r == 6'h00) ? nxt_byte : obyte_r;
    out_lanes = 4'h0;
    oe_lanes = 4'h0;
    case (width_r)
      // single line answers on lane 1 only, lane 0 stays an input
      2'd0: begin
        out_lanes = {2'b00, out_src[7], 1'b0};
        oe_lanes = 4'h2;
      end
      // dual answers on lanes 1 and 0, high bit on lane 1
      2'd1: begin
        out_lanes = {2'b00, out_src[7:6]};
        oe_lanes = 4'h3;
      end
      // quad answers a nibble per clock, high nibble first
      2'd2: begin
        out_lanes = out_src[7:4];
        oe_lanes = 4'hF;
      end
      default: begin
        out_lanes = 4'h0;
        oe_lanes = 4'h0;
      end
    endcase
  end

  // ==========================================================
  // command sequencer
  always @(posedge CLK_SYS) begin
    if (RST) begin
      state_r <= S_OP;
      op_r <= 8'h00;
      addr_r <= 24'h000000;
      cnt_r <= 6'h00;
      width_r <= 2'd0;
      obyte_r <= 8'h00;
      oidx_r <= 7'h00;
      sec_ptr_r <= 10'h000;
      sec_reg_r <= 2'd0;
      id_sel_r <= 1'b0;
      pend_r <= 1'b0;
      sel_d_r <= 1'b0;
      IO_OUT <= 4'h0;
      IO_OE <= 4'h0;
      SEC_ADDR <= 12'h000;
      set_one <= 1'b0;
      clr_one <= 1'b0;
      set_all <= 1'b0;
      clr_all <= 1'b0;
      WEL_CLEAR <= 1'b0;
      LOCK_BITS_ACTIVE <= 1'b0;
      INDEX_LOCKED <= 1'b1;
    end else begin
      sel_d_r <= sel;
      set_one <= 1'b0;
      clr_one <= 1'b0;
      set_all <= 1'b0;
      clr_all <= 1'b0;
      WEL_CLEAR <= 1'b0;
      // lock array governs only with scheme select set
      LOCK_BITS_ACTIVE <= PROTECTION_SCHEME_SELECT;
      if (state_r == S_OP) begin
        INDEX_LOCKED <= PROTECTION_SCHEME_SELECT ? lock_bit : 1'b0;
      end
      if (!sel) begin
        // apply lock change only at deselect after complete command
        if (sel_d_r && pend_r) begin
          set_one <= (op_r == `FLK_OP_LOCK);
          clr_one <= (op_r == `FLK_OP_UNLOCK);
          set_all <= (op_r == `FLK_OP_GLOCK);
          clr_all <= (op_r == `FLK_OP_GUNLOCK);
          WEL_CLEAR <= 1'b1;
        end
        state_r <= S_OP;
        cnt_r <= 6'h00;
        width_r <= 2'd0;
        pend_r <= 1'b0;
        op_r <= 8'h00;
        IO_OE <= 4'h0;
      end else if (rise) begin
        case (state_r)
          S_OP: begin
            op_r <= {op_r[6:0], io[0]};
            cnt_r <= cnt_r + 6'd1;
            if (cnt_r == `FLK_OPBITS - 6'd1) begin
              cnt_r <= 6'h00;
              state_r <= S_ADDR;
              case ({op_r[6:0], io[0]})
                // security read while busy is discarded
                `FLK_OP_SECRD: if (BUSY) state_r <= S_IGNORE;
                `FLK_OP_LOCK, `FLK_OP_UNLOCK, `FLK_OP_RDLOCK, `FLK_OP_UID: ;
                `FLK_OP_ID2: width_r <= 2'd1;
                `FLK_OP_ID4: width_r <= 2'd2;
                // global commands need the write enable latch
                `FLK_OP_GLOCK, `FLK_OP_GUNLOCK: begin
                  pend_r <= WRITE_ENABLE_LATCH;
                  state_r <= S_WAIT;
                end
                default: state_r <= S_IGNORE;
              endcase
            end
          end
          S_ADDR: begin
            addr_r <= addr_shift;
            cnt_r <= cnt_r + step;
            if (cnt_r + step == `FLK_ADDRBITS) begin
              cnt_r <= 6'h00;
              case (op_r)
                // single lock commands need write enable latch
                `FLK_OP_LOCK, `FLK_OP_UNLOCK: begin
                  pend_r <= WRITE_ENABLE_LATCH;
                  state_r <= S_WAIT;
                end
                `FLK_OP_RDLOCK: state_r <= S_DATA;
                // dual id takes the mode byte in the dummy phase, as four dual clocks
                `FLK_OP_ID2: state_r <= S_DUMMY;
                default: state_r <= S_DUMMY;
              endcase
              // register number and byte offset from address fields
              sec_reg_r <= addr_shift[13:12];
              sec_ptr_r <= addr_shift[9:0];
              id_sel_r <= addr_shift[0];
            end
          end
          S_DUMMY: begin
            cnt_r <= cnt_r + step;
            // eight dummy clocks single; mode byte alone dual; mode byte plus four dummies quad
            // compare with >= so an odd lane count cannot step past the end
            if (cnt_r + step >= dummy_bits) begin
              cnt_r <= 6'h00;
              oidx_r <= 7'h00;
              state_r <= S_DATA;
            end
          end
          S_WAIT: pend_r <= 1'b0; // extra clocks make the sequence invalid
          default: ;
        endcase
      end else if (fall && state_r == S_DATA) begin
        // data out on falling edges, most significant first
        // the enable rises with the first bit, never ahead of valid data
        obyte_r <= out_src << step;
        IO_OUT <= out_lanes;
        IO_OE <= oe_lanes;
        if (cnt_r + step == 6'd8) begin
          cnt_r <= 6'h00;
          oidx_r <= oidx_r + 7'd8;
          id_sel_r <= ~id_sel_r;
          // byte pointer wraps 3FFh to 00h
          sec_ptr_r <= (sec_ptr_r == `FLK_SEC_WRAP) ? 10'h000 : sec_ptr_r + 10'd1;
        end else begin
          cnt_r <= cnt_r + step;
        end
      end
      SEC_ADDR <= {sec_reg_r, sec_ptr_r};
    end
  end
endmodule

//--- hdl/flk_regs.vh
// constants for the flash lock / security register / identity command block
// assumes inclusion by flk_top.v and flk_lockmem.v only
`ifndef FLK_REGS_VH
`define FLK_REGS_VH
// ==========================================================
// opcodes
`define FLK_OP_SECRD 8'h48
`define FLK_OP_LOCK 8'h36
`define FLK_OP_UNLOCK 8'h39
`define FLK_OP_RDLOCK 8'h3D
`define FLK_OP_GLOCK 8'h7E
`define FLK_OP_GUNLOCK 8'h98
`define FLK_OP_ID2 8'h92
`define FLK_OP_ID4 8'h94
`define FLK_OP_UID 8'h4B
// ==========================================================
// field positions and counts
`define FLK_ADDR_UPPER_MSB 23
`define FLK_ADDR_UPPER_LSB 16
`define FLK_SEC_WRAP 10'h3FF
`define FLK_LOCK_ADDR_MSB 23
`define FLK_LOCK_ADDR_LSB 16
`define FLK_NLOCK 256
`define FLK_LOCK_RESET 1'h1
`define FLK_DUMMY_SEC 6'h08
`define FLK_DUMMY_UID 6'h08
`define FLK_DUMMY_ID2 6'h08
`define FLK_DUMMY_ID4 6'h18
`define FLK_OPBITS 6'h08
`define FLK_ADDRBITS 6'h18
`endif

//--- hdl/flk_lockmem.v
// volatile block/sector lock bit array with single and global updates
// assumes updates arrive as one-cycle pulses on the system clock
`timescale 1ns/1ps
`include "flk_regs.vh"
module flk_lockmem (
  // clock and reset
  input wire clk,
  input wire rst,
  // update requests
  input wire set_one,
  input wire clr_one,
  input wire set_all,
  input wire clr_all,
  input wire [7:0] idx,
  // lookup
  output wire bit_out
);
  reg [`FLK_NLOCK-1:0] lock_r;
  genvar g;
  // ==========================================================
  // per-entry lock flops
  generate
    for (g = 0; g < `FLK_NLOCK; g = g + 1) begin : gl
      always @(posedge clk) begin
        if (rst) begin
          lock_r[g] <= `FLK_LOCK_RESET;
        end else if (set_all) begin
          lock_r[g] <= 1'b1;
        end else if (clr_all) begin
          lock_r[g] <= 1'b0;
        end else if (set_one && idx == g) begin
          lock_r[g] <= 1'b1;
        end else if (clr_one && idx == g) begin
          lock_r[g] <= 1'b0;
        end
      end
    end
  endgenerate
  assign bit_out = lock_r[idx];
endmodule

//--- test/flk_monitor.sv
// checker for the lock, security read and identity command block
// assumes it is bound to flk_top and sees its ports only
`timescale 1ns/1ps
module flk_monitor (
  // system
  input wire CLK_SYS,
  input wire RST,
  // link and state
  input wire SCLK,
  input wire CS_N,
  input wire WRITE_ENABLE_LATCH,
  input wire PROTECTION_SCHEME_SELECT,
  input wire [3:0] IO_OUT,
  input wire [3:0] IO_OE,
  // results
  input wire LOCK_BITS_ACTIVE,
  input wire INDEX_LOCKED,
  input wire WEL_CLEAR
);
  // ==========================================================
  // assertions, all in the system clock domain
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  property p_rst_oe;
    $fell(RST) |-> IO_OE == 4'h0;
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("output enabled after reset");
  property p_rst_lk;
    $fell(RST) |-> INDEX_LOCKED;
  endproperty
  a_rst_lk: assert property (p_rst_lk) else $error("index unlocked after reset");
  property p_scheme;
    $changed(PROTECTION_SCHEME_SELECT) |-> ##[1:4] LOCK_BITS_ACTIVE == PROTECTION_SCHEME_SELECT;
  endproperty
  a_scheme: assert property (p_scheme) else $error("scheme select not followed");
  property p_wel_gate;
    WEL_CLEAR |-> WRITE_ENABLE_LATCH;
  endproperty
  a_wel_gate: assert property (p_wel_gate) else $error("lock change without write enable");
  property p_wel_cs;
    WEL_CLEAR |-> CS_N && $past(CS_N);
  endproperty
  a_wel_cs: assert property (p_wel_cs) else $error("lock change while selected");
  property p_wel_once;
    WEL_CLEAR |=> !WEL_CLEAR;
  endproperty
  a_wel_once: assert property (p_wel_once) else $error("lock change pulse too long");
  property p_oe_end;
    $rose(CS_N) |-> ##[1:8] IO_OE == 4'h0;
  endproperty
  a_oe_end: assert property (p_oe_end) else $error("output kept after deselect");
  property p_fall_out;
    !CS_N && IO_OE[1] && $past(IO_OE[1]) && $changed(IO_OUT) |-> !$past(SCLK, 2);
  endproperty
  a_fall_out: assert property (p_fall_out) else $error("data changed off the falling edge");
endmodule
bind flk_top flk_monitor flk_monitor_inst (.CLK_SYS(CLK_SYS), .RST(RST), .SCLK(SCLK),
  .CS_N(CS_N), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
  .PROTECTION_SCHEME_SELECT(PROTECTION_SCHEME_SELECT), .IO_OUT(IO_OUT), .IO_OE(IO_OE),
  .LOCK_BITS_ACTIVE(LOCK_BITS_ACTIVE), .INDEX_LOCKED(INDEX_LOCKED), .WEL_CLEAR(WEL_CLEAR));

//--- test/flk_host.sv
// host serial controller model that drives the link pins
// assumes the system clock paces it, four cycles per serial half period
`timescale 1ns/1ps
module flk_host (
  // pacing clock
  input wire clk,
  // link pins
  output reg sclk,
  output reg cs_n,
  output reg [3:0] io,
  input wire [3:0] dout,
  input wire [3:0] doe
);
  reg oe_seen;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io = 4'h0;
    oe_seen = 1'b0;
  end
  task wait_n(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // ==========================================================
  // framing: serial clock stands low outside frames
  task sel;
    @(posedge clk);
    cs_n <= 1'b0;
    oe_seen = 1'b0;
    wait_n(4);
  endtask
  task desel;
    wait_n(4);
    cs_n <= 1'b1;
    wait_n(12);
  endtask
  // data set low, taken on rise
  task tick(input [3:0] d, output [3:0] q);
    io <= d;
    wait_n(4);
    sclk <= 1'b1;
    wait_n(2);
    q = dout;
    oe_seen = oe_seen | (|doe);
    wait_n(2);
    sclk <= 1'b0;
  endtask
  // msb first, w bits per clock
  task send(input [31:0] v, input integer n, input integer w);
    reg [3:0] q;
    integer i;
    for (i = n; i > 0; i = i - w) begin
      tick(4'((v >> (i - w)) & ((1 << w) - 1)), q);
    end
  endtask
  // data lines toggle while the device talks, so a stale level never passes
  task recv(output [127:0] v, input integer n, input integer w);
    reg [3:0] q;
    integer i;
    v = 128'h0;
    for (i = 0; i < n; i = i + w) begin
      tick(~io, q);
      v = (v << w) | ((w == 1) ? {3'h0, q[1]} : (w == 2) ? {2'h0, q[1:0]} : q);
    end
  endtask
endmodule

//--- test/flk_top_test.sv
// self-checking bench for the lock, security read and identity commands
// assumes the host model paces the link at 200 ns per serial clock
`timescale 1ns/1ps
module flk_top_test;
  localparam [7:0] MK = 8'h3C; // arbitrary value
  localparam [7:0] DV = 8'h7D; // arbitrary value
  localparam [127:0] UID = 128'hF0E1D2C3B4A5968778695A4B3C2D1E0F; // arbitrary value
  reg clk, rst, busy, write_enable_latch, pss;
  reg [7:0] chk_idx;
  reg [127:0] v;
  wire sclk, cs_n, lk_act, idx_lk, wel_clr;
  integer n_clr;
  wire [3:0] io_in, io_out, io_oe;
  wire [11:0] sec_addr;
  integer n_fail, n_tests;
  // security array content, differs per register and per low offset byte
  function [7:0] sec_f(input [11:0] a);
    sec_f = a[7:0] ^ {a[11:10], 6'h15};
  endfunction
  // ==========================================================
  // design and host model
  flk_top #(.MAKER_CODE(MK), .DEVICE_CODE(DV), .UNIQUE_ID(UID)) flk_top_inst (
    .CLK_SYS(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .IO_IN(io_in), .IO_OUT(io_out),
    .IO_OE(io_oe), .BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch), .PROTECTION_SCHEME_SELECT(pss),
    .PROTECT_COMPLEMENT(1'b0), .SECTOR_GRANULARITY(1'b0), .TOP_BOTTOM_SELECT(1'b0),
    .BLOCK_PROTECT_FIELD(3'h0), .CHECK_INDEX(chk_idx), .SEC_ADDR(sec_addr),
    .SEC_DATA(sec_f(sec_addr)), .LOCK_BITS_ACTIVE(lk_act), .INDEX_LOCKED(idx_lk),
    .WEL_CLEAR(wel_clr));
  flk_host flk_host_inst (.clk(clk), .sclk(sclk), .cs_n(cs_n), .io(io_in), .dout(io_out),
    .doe(io_oe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // count applied lock changes by their one-cycle pulses
  always @(posedge clk) begin
    if (rst)
      n_clr <= 0;
    else if (wel_clr)
      n_clr <= n_clr + 1;
  end
  // ==========================================================
  // helpers
  task chk(input [127:0] seen, input [127:0] exp, input string what);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
    $display("test %s done", what);
  endtask
  task cmd(input [7:0] op, input [31:0] a, input integer n_a);
    flk_host_inst.sel;
    flk_host_inst.send({24'h0, op}, 8, 1);
    flk_host_inst.send(a, n_a, 1);
    flk_host_inst.desel;
  endtask
  task rd(input [7:0] op, input [31:0] a, input integer w_a, input [31:0] dm,
    input integer n_d, input integer n_r, input integer w_r);
    flk_host_inst.sel;
    flk_host_inst.send({24'h0, op}, 8, 1);
    flk_host_inst.send(a, 24, w_a);
    flk_host_inst.send(dm, n_d, w_a);
    flk_host_inst.recv(v, n_r, w_r);
    flk_host_inst.desel;
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    n_fail = n_fail + 1;
    conclude;
  end
  // ==========================================================
  // tests
  initial begin
    rst = 1'b1;
    busy = 1'b0;
    write_enable_latch = 1'b0;
    pss = 1'b1;
    chk_idx = 8'h05;
    n_fail = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h3D, 32'h050000, 1, 0, 0, 8, 1);
    chk(v[0], 1'b1, "lock_read_reset");
    chk(idx_lk, 1'b1, "index_locked_reset");
    cmd(8'h39, 32'h050000, 24);
    chk(idx_lk, 1'b1, "unlock_no_wel");
    write_enable_latch <= 1'b1;
    cmd(8'h39, 32'h050000, 24);
    chk(idx_lk, 1'b0, "unlock_one");
    cmd(8'h36, 32'h050000, 24);
    rd(8'h3D, 32'h050000, 1, 0, 0, 8, 1);
    chk(v[0], 1'b1, "lock_one");
    cmd(8'h98, 0, 0);
    rd(8'h3D, 32'hFF0000, 1, 0, 0, 8, 1);
    chk(v[0], 1'b0, "global_unlock");
    cmd(8'h36, 32'h00FF00, 16);
    rd(8'h3D, 32'hFF0000, 1, 0, 0, 8, 1);
    chk(v[0], 1'b0, "truncated_lock");
    cmd(8'h7E, 0, 0);
    rd(8'h3D, 32'h000000, 1, 0, 0, 8, 1);
    chk(v[0], 1'b1, "global_lock");
    chk(n_clr, 4, "lock_pulses");
    pss <= 1'b0;
    repeat (4) @(posedge clk);
    chk(lk_act, 1'b0, "scheme_off");
    pss <= 1'b1;
    rd(8'h48, 32'h0023FF, 1, 0, 8, 16, 1);
    chk(v[15:0], {sec_f(12'hBFF), sec_f(12'h800)}, "sec_wrap");
    rd(8'h48, 32'h012000, 1, 0, 8, 8, 1);
    chk(v[7:0], 8'h00, "sec_upper_addr");
    busy <= 1'b1;
    rd(8'h48, 32'h001000, 1, 0, 8, 8, 1);
    chk(flk_host_inst.oe_seen, 1'b0, "sec_busy");
    busy <= 1'b0;
    rd(8'h92, 0, 2, 32'hF0, 8, 32, 2);
    chk(v[31:0], {MK, DV, MK, DV}, "id_dual");
    rd(8'h94, 0, 4, 32'hF00000, 24, 16, 4);
    chk(v[15:0], {MK, DV}, "id_quad");
    rd(8'h4B, 0, 1, 0, 8, 128, 1);
    chk(v, UID, "unique_id");
    cmd(8'h98, 0, 0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h3D, 32'h770000, 1, 0, 0, 8, 1);
    chk(v[0], 1'b1, "lock_after_reset");
    conclude;
  end
endmodule
